//--- rtl/epi_top.sv
// External pin interrupt unit: two sensed lines and three pin-change groups.
// Assumes a classic Wishbone master on clk_i and a core that pulses an
// acknowledge per source when it vectors.
// Behaviour
// [RULE_01] Line 1 sense in bits 3:2
// [RULE_02] Line 0 sense in bits 1:0
// [RULE_03] Sample pin before edge detection
// [RULE_04] Source holds low level until instruction ends
// [RULE_05] Line request needs enable and global enable
// [RULE_06] Pins detected even when driven as outputs
// [RULE_07] Each line has its own vector
// [RULE_08] Edge on line sets its flag
// [RULE_09] Acknowledge or write-one clears line flag
// [RULE_10] Level mode holds line flag zero
// [RULE_11] Unused register bits read zero
// [RULE_12] Three group enables gated by global enable
// [RULE_13] Any masked pin change raises group
// [RULE_14] Each group has its own vector
// [RULE_15] Pin change sets group flag
// [RULE_16] Acknowledge or write-one clears group flag
// [RULE_17] Mask bit works only with group enable
// [RULE_18] Pin change detected on synchronised samples
// [RULE_19] Core acknowledge clears matching flag
`timescale 1ns/1ps
module epi_top (
   // Clock and reset
   input  wire logic                                          clk_i,
   input  wire logic                                          srst_i,
   // Wishbone slave
   input  wire epi_pkg::epi_wb_req_type                       wb_req_i,
   output epi_pkg::epi_wb_rsp_type                            wb_rsp_o,
   // Pins, sampled at the pad whatever the port direction
   input  wire logic [epi_pkg::NUM_LINES-1:0]                 ext_line_i,
   input  wire logic [epi_pkg::NUM_GROUPS*epi_pkg::GRP_W-1:0] group_pins_i,
   // Core side
   input  wire logic                                          cpu_gie_i,
   input  wire logic [epi_pkg::NUM_LINES-1:0]                 line_ack_i,
   input  wire logic [epi_pkg::NUM_GROUPS-1:0]                group_ack_i,
   output logic      [epi_pkg::NUM_LINES-1:0]                 line_irq_o,
   output logic      [epi_pkg::NUM_GROUPS-1:0]                group_irq_o,
   output logic                                               cpu_gie_o
);

   localparam int NL = epi_pkg::NUM_LINES;
   localparam int NG = epi_pkg::NUM_GROUPS;
   localparam int GW = epi_pkg::GRP_W;

   // Address match of a register index against the word address
   function automatic logic hit(input logic [epi_pkg::ADDR_W-1:0] adr, input logic [7:0] idx);
      hit = (adr[epi_pkg::ADDR_W-1:2] == idx);
   endfunction

   // Registers
   logic [7:0]       sense_q;
   logic [NL-1:0]    line_en_q;
   logic [NG-1:0]    grp_en_q;
   logic [NG-1:0]    grp_fl_q;
   logic [NG-1:0]    grp_fl_d;
   logic [GW-1:0]    mask_q [NG];
   logic             gie_q;
   logic             ack_q;
   logic [31:0]      rdat_q;
   logic [7:0]       rd_byte;

   // Synchronised pins and pin history
   logic [NL-1:0]    line_s;
   logic [NG*GW-1:0] grp_s;
   logic [NG*GW-1:0] grp_prev_q;
   logic [NL-1:0]    line_fl;
   logic [NL-1:0]    line_cond;
   logic [NG-1:0]    grp_change;

   // Bus decode
   logic             req;
   logic             wr0;
   logic             wr_sense;
   logic             wr_len;
   logic             wr_lfl;
   logic             wr_gen;
   logic             wr_gfl;
   logic             wr_gie;
   logic [NG-1:0]    wr_mask;
   logic [7:0]       wb_byte;

   assign req      = wb_req_i.cyc & wb_req_i.stb & ~ack_q;
   assign wr0      = req & wb_req_i.we & wb_req_i.sel[0];
   assign wb_byte  = wb_req_i.dat[7:0];
   assign wr_sense = wr0 & hit(wb_req_i.adr, epi_pkg::SENSE_IDX);
   assign wr_len   = wr0 & hit(wb_req_i.adr, epi_pkg::LINE_EN_IDX);
   assign wr_lfl   = wr0 & hit(wb_req_i.adr, epi_pkg::LINE_FL_IDX);
   assign wr_gen   = wr0 & hit(wb_req_i.adr, epi_pkg::GRP_EN_IDX);
   assign wr_gfl   = wr0 & hit(wb_req_i.adr, epi_pkg::GRP_FL_IDX);
   assign wr_gie   = wr0 & hit(wb_req_i.adr, epi_pkg::GIE_IDX);
   assign wr_mask[0] = wr0 & hit(wb_req_i.adr, epi_pkg::MASK0_IDX);
   assign wr_mask[1] = wr0 & hit(wb_req_i.adr, epi_pkg::MASK1_IDX);
   assign wr_mask[2] = wr0 & hit(wb_req_i.adr, epi_pkg::MASK2_IDX);

   // Pins pass two flops first; pad level is seen even when pin drives out
   epi_sync #(.WIDTH(NL)) u_line_sync ( // see [RULE_03] see [RULE_06]
      .clk_i  (clk_i),
      .srst_i (srst_i),
      .pin_i  (ext_line_i),
      .sync_o (line_s)
   );

   epi_sync #(.WIDTH(NG*GW)) u_grp_sync ( // see [RULE_18] see [RULE_06]
      .clk_i  (clk_i),
      .srst_i (srst_i),
      .pin_i  (group_pins_i),
      .sync_o (grp_s)
   );

   // Per-line sense decode and flag; line n sense at bits 2n+1:2n
   generate
      for (genvar n = 0; n < NL; n++)
      begin : g_line
         epi_line u_line ( // see [RULE_01] see [RULE_02] see [RULE_08] see [RULE_10]
            .clk_i    (clk_i),
            .srst_i   (srst_i),
            .pin_i    (line_s[n]),
            .sense_i  (epi_pkg::epi_sense_type'(sense_q[n*epi_pkg::SENSE_W +: epi_pkg::SENSE_W])),
            .clr_wr_i (wr_lfl & wb_byte[n]),  // see [RULE_09]
            .ack_i    (line_ack_i[n]),        // see [RULE_19]
            .flag_o   (line_fl[n]),
            .cond_o   (line_cond[n])
         );
         // Own request per line, gated by enable and global enable
         assign line_irq_o[n] = line_cond[n] & line_en_q[n] & gie_q; // see [RULE_05] see [RULE_07]
      end
   endgenerate

   // Group change detect over masked pins; flag set wins over clear
   generate
      for (genvar g = 0; g < NG; g++)
      begin : g_grp
         assign grp_change[g] = |((grp_s[g*GW +: GW] ^ grp_prev_q[g*GW +: GW]) & mask_q[g]); // see [RULE_13]
         assign grp_fl_d[g]   = grp_change[g] |
                                (grp_fl_q[g] & ~((wr_gfl & wb_byte[g]) | group_ack_i[g])); // see [RULE_15] see [RULE_16] see [RULE_19]
         // Mask only counts through the group enable and global enable
         assign group_irq_o[g] = grp_fl_q[g] & grp_en_q[g] & gie_q; // see [RULE_12] see [RULE_14] see [RULE_17]
      end
   endgenerate

   // Register file writes; reserved bits are never stored
   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         sense_q    <= epi_pkg::REG_RST;
         line_en_q  <= '0;
         grp_en_q   <= '0;
         grp_fl_q   <= '0;
         gie_q      <= 1'b0;
         grp_prev_q <= '1;
         for (int i = 0; i < NG; i++)
         begin
            mask_q[i] <= epi_pkg::REG_RST;
         end
      end
      else
      begin
         grp_prev_q <= grp_s;
         grp_fl_q   <= grp_fl_d;
         if (wr_sense)
         begin
            sense_q <= {4'h0, wb_byte[3:0]}; // see [RULE_11]
         end
         if (wr_len)
         begin
            line_en_q <= wb_byte[NL-1:0];
         end
         if (wr_gen)
         begin
            grp_en_q <= wb_byte[NG-1:0];
         end
         if (wr_gie)
         begin
            gie_q <= wb_byte[0];
         end
         for (int i = 0; i < NG; i++)
         begin
            if (wr_mask[i])
            begin
               mask_q[i] <= (i == 1) ? (wb_byte & epi_pkg::MASK1_VALID) : wb_byte;
            end
         end
      end
   end

   // Read mux; unused bits and unmapped addresses read zero
   assign rd_byte =
      hit(wb_req_i.adr, epi_pkg::SENSE_IDX)   ? sense_q :
      hit(wb_req_i.adr, epi_pkg::LINE_EN_IDX) ? {6'h00, line_en_q} :
      hit(wb_req_i.adr, epi_pkg::LINE_FL_IDX) ? {6'h00, line_fl} :
      hit(wb_req_i.adr, epi_pkg::GRP_EN_IDX)  ? {5'h00, grp_en_q} :
      hit(wb_req_i.adr, epi_pkg::GRP_FL_IDX)  ? {5'h00, grp_fl_q} :
      hit(wb_req_i.adr, epi_pkg::MASK0_IDX)   ? mask_q[0] :
      hit(wb_req_i.adr, epi_pkg::MASK1_IDX)   ? mask_q[1] :
      hit(wb_req_i.adr, epi_pkg::MASK2_IDX)   ? mask_q[2] :
      hit(wb_req_i.adr, epi_pkg::GIE_IDX)     ? {7'h00, gie_q} : 8'h00; // see [RULE_11]

   // One-cycle ack; every address answers, so the bus never hangs
   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         ack_q  <= 1'b0;
         rdat_q <= epi_pkg::UNMAPPED_RD;
      end
      else
      begin
         ack_q  <= req;
         rdat_q <= {24'h000000, rd_byte};
      end
   end

   assign wb_rsp_o.ack = ack_q;
   assign wb_rsp_o.dat = rdat_q;
   assign cpu_gie_o    = gie_q;

endmodule

//--- rtl/epi_pkg.sv
// Package for the external pin interrupt unit: register map, field layout,
// sense encodings and bus carrier types. Assumes a 32-bit classic Wishbone bus.
package epi_pkg;

   // Register word indices, matched against address bits 9:2; printed indices are not all multiples of four
   localparam logic [7:0] SENSE_IDX   = 8'h69;
   localparam logic [7:0] LINE_EN_IDX = 8'h3d;
   localparam logic [7:0] LINE_FL_IDX = 8'h3c;
   localparam logic [7:0] GRP_EN_IDX  = 8'h68;
   localparam logic [7:0] GRP_FL_IDX  = 8'h3b;
   localparam logic [7:0] MASK0_IDX   = 8'h6b;
   localparam logic [7:0] MASK1_IDX   = 8'h6c;
   localparam logic [7:0] MASK2_IDX   = 8'h6d;
   localparam logic [7:0] GIE_IDX     = 8'h5f;
   localparam int         ADDR_W      = 10;

   // Widths and reset values
   localparam int         NUM_LINES   = 2;
   localparam int         NUM_GROUPS  = 3;
   localparam int         GRP_W       = 8;
   localparam logic [7:0] REG_RST     = 8'h00;
   localparam logic [7:0] MASK1_VALID = 8'h7f;
   localparam logic [31:0] UNMAPPED_RD = 32'h0000_0000;

   // Sense field layout: line n at bits 2n+1:2n
   localparam int         SENSE_W     = 2;

   typedef enum logic [1:0] {
      SENSE_LOW     = 2'h0,
      SENSE_CHANGE  = 2'h1,
      SENSE_FALLING = 2'h2,
      SENSE_RISING  = 2'h3
   } epi_sense_type;

   // Wishbone request carrier
   typedef struct packed {
      logic              cyc;
      logic              stb;
      logic              we;
      logic [3:0]        sel;
      logic [ADDR_W-1:0] adr;
      logic [31:0]       dat;
   } epi_wb_req_type;

   // Wishbone answer carrier
   typedef struct packed {
      logic        ack;
      logic [31:0] dat;
   } epi_wb_rsp_type;

endpackage

//--- rtl/epi_sync.sv
// Two-flop synchroniser for a vector of pin levels.
// Assumes the pins are asynchronous to clk_i; first stage feeds only the second.
`timescale 1ns/1ps
module epi_sync #(
   parameter int WIDTH = 8
) (
   // Clock and reset
   input  wire logic             clk_i,
   input  wire logic             srst_i,
   // Pins in, synchronised level out
   input  wire logic [WIDTH-1:0] pin_i,
   output logic      [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   // Two stages; reset forces a quiet idle-high level
   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         meta_q <= '1;
         sync_q <= '1;
      end
      else
      begin
         meta_q <= pin_i;
         sync_q <= meta_q;
      end
   end

   assign sync_o = sync_q;

endmodule

//--- rtl/epi_line.sv
// One external interrupt line: sense decode, edge detection and sticky flag.
// Assumes a synchronised pin level; the flag clears by acknowledge or write-one.
`timescale 1ns/1ps
module epi_line (
   // Clock and reset
   input  wire logic                    clk_i,
   input  wire logic                    srst_i,
   // Synchronised pin and configuration
   input  wire logic                    pin_i,
   input  wire epi_pkg::epi_sense_type  sense_i,
   // Flag clearing
   input  wire logic                    clr_wr_i,
   input  wire logic                    ack_i,
   // Status
   output logic                         flag_o,
   output logic                         cond_o
);

   logic prev_q;
   logic flag_q;
   logic flag_d;
   logic rise;
   logic fall;
   logic edge_hit;
   logic level_mode;

   // Edge detection on the sampled level
   assign rise       = pin_i & ~prev_q;
   assign fall       = ~pin_i & prev_q;
   assign level_mode = (sense_i == epi_pkg::SENSE_LOW);
   assign edge_hit   = (sense_i == epi_pkg::SENSE_CHANGE)  ? (rise | fall) :
                       (sense_i == epi_pkg::SENSE_FALLING) ? fall :
                       (sense_i == epi_pkg::SENSE_RISING)  ? rise : 1'b0;

   // Set wins over clear; level mode pins the flag at zero
   assign flag_d = level_mode ? 1'b0 : (edge_hit | (flag_q & ~(clr_wr_i | ack_i)));

   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         prev_q <= 1'b1;
         flag_q <= 1'b0;
      end
      else
      begin
         prev_q <= pin_i;
         flag_q <= flag_d;
      end
   end

   assign flag_o = flag_q;
   assign cond_o = level_mode ? ~pin_i : flag_q;

endmodule

//--- dv/epi_top_checker.sv
// Checker for epi_top: bus handshake, read-back zeros and request gating.
// Assumes it is bound to epi_top and sees only that module's ports.
`timescale 1ns/1ps
module epi_top_checker (
   // Clock and reset
   input wire logic                    clk_i,
   input wire logic                    srst_i,
   // Bus and pins
   input wire epi_pkg::epi_wb_req_type wb_req_i,
   input wire epi_pkg::epi_wb_rsp_type wb_rsp_o,
   input wire logic [1:0]              ext_line_i,
   input wire logic [23:0]             group_pins_i,
   // Core side
   input wire logic                    cpu_gie_i,
   input wire logic [1:0]              line_ack_i,
   input wire logic [2:0]              group_ack_i,
   input wire logic [1:0]              line_irq_o,
   input wire logic [2:0]              group_irq_o,
   input wire logic                    cpu_gie_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (srst_i);

   // Request not yet answered, and a write to the global enable
   wire req_new = wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack;
   wire gie_wr  = req_new && wb_req_i.we && wb_req_i.sel[0] && wb_req_i.adr == 10'h17c;

   // Answer timing; a stuck ack would double-count writes
   ack_follows_a: assert property (req_new |=> wb_rsp_o.ack) else $error("ack missing");
   ack_pulse_a: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack) else $error("ack too long");
   ack_cause_a: assert property (wb_rsp_o.ack |-> $past(req_new)) else $error("ack without request");
   upper_zero_a: assert property (wb_rsp_o.ack |-> wb_rsp_o.dat[31:8] == 24'h0)
      else $error("upper read bits set");
   unmapped_zero_a: assert property (req_new && !wb_req_i.we && wb_req_i.adr == 10'h000 |=>
      wb_rsp_o.dat == 32'h0) else $error("unmapped read not zero");
   // Gating: requests and the enable copy come from the same flop, so no lag is allowed
   gie_set_a: assert property (gie_wr && wb_req_i.dat[0] |=> cpu_gie_o)
      else $error("global enable not set");
   line_gate_a: assert property (|line_irq_o |-> cpu_gie_o)
      else $error("line request without global enable");
   group_gate_a: assert property (|group_irq_o |-> cpu_gie_o)
      else $error("group request without global enable");
   // Pads quiet for three samples leave nothing in the sync pipe to set the flag again
   group_clear_a: assert property (|group_ack_i && group_pins_i == $past(group_pins_i)
      && group_pins_i == $past(group_pins_i, 2) && group_pins_i == $past(group_pins_i, 3)
      |=> (group_irq_o & $past(group_ack_i)) == 3'h0)
      else $error("group request not cleared by acknowledge");

   // Main scenarios reached
   cover property (|line_irq_o);
   cover property (|group_irq_o);
   cover property (gie_wr);
   cover property (|group_ack_i);
endmodule

bind epi_top epi_top_checker u_epi_top_checker (.clk_i(clk_i), .srst_i(srst_i), .wb_req_i(wb_req_i),
   .wb_rsp_o(wb_rsp_o), .ext_line_i(ext_line_i), .group_pins_i(group_pins_i), .cpu_gie_i(cpu_gie_i),
   .line_ack_i(line_ack_i), .group_ack_i(group_ack_i), .line_irq_o(line_irq_o),
   .group_irq_o(group_irq_o), .cpu_gie_o(cpu_gie_o));

//--- dv/epi_pin_model.sv
// Off-chip drivers for the external lines and the pin-change groups.
// Assumes pulled-up idle pins; the bench calls the tasks by hierarchy.
`timescale 1ns/1ps
module epi_pin_model (
   // Clock
   input wire logic    clk_i,
   // Pads towards the unit
   output logic [1:0]  ext_line_o,
   output logic [23:0] group_pins_o
);
   // Pull-ups hold every pad high until driven
   initial
   begin
      ext_line_o   = 2'h3;
      group_pins_o = 24'hff_ffff;
   end

   // Level held three cycles, well past one period and one instruction
   task automatic set_line(input int idx, input logic v);
      @(posedge clk_i);
      ext_line_o[idx] <= v;
      repeat (3) @(posedge clk_i);
   endtask

   // Group pads change together and are held alike
   task automatic set_pins(input logic [23:0] v);
      @(posedge clk_i);
      group_pins_o <= v;
      repeat (3) @(posedge clk_i);
   endtask
endmodule

//--- dv/tb.sv
// Self-checking bench for epi_top: registers, line senses and groups.
// Assumes the pin model drives the pads; the bench plays bus and core.
`timescale 1ns/1ps
module tb;
   localparam logic [9:0] A_SEN = 10'h1a4;
   localparam logic [9:0] A_LEN = 10'h0f4;
   localparam logic [9:0] A_LFL = 10'h0f0;
   localparam logic [9:0] A_GEN = 10'h1a0;
   localparam logic [9:0] A_GFL = 10'h0ec;
   localparam logic [9:0] A_GIE = 10'h17c;
   // Register table: address and value read back after writing all ones
   logic [9:0]              ra [7] = '{A_SEN, A_LEN, A_GEN, 10'h1b0, A_LFL, A_GFL, 10'h000};
   logic [7:0]              rv [7] = '{8'h0f, 8'h03, 8'h07, 8'h7f, 8'h00, 8'h00, 8'h00};
   logic                    clk_i;
   logic                    srst_i;
   logic                    cpu_gie_i;
   logic                    cpu_gie_o;
   logic [1:0]              line_ack_i;
   logic [1:0]              line_irq_o;
   logic [1:0]              ext_line;
   logic [2:0]              group_ack_i;
   logic [2:0]              group_irq_o;
   logic [23:0]             group_pins;
   logic [31:0]             rd;
   logic [7:0]              eb;
   epi_pkg::epi_wb_req_type wb_req_i;
   epi_pkg::epi_wb_rsp_type wb_rsp_o;
   int                      bad_count;
   int                      cmp_count;

   // Clock
   initial
   begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   epi_top u_epi_top (.clk_i(clk_i), .srst_i(srst_i), .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o),
      .ext_line_i(ext_line), .group_pins_i(group_pins), .cpu_gie_i(cpu_gie_i), .line_ack_i(line_ack_i),
      .group_ack_i(group_ack_i), .line_irq_o(line_irq_o), .group_irq_o(group_irq_o), .cpu_gie_o(cpu_gie_o));
   epi_pin_model u_epi_pin_model (.clk_i(clk_i), .ext_line_o(ext_line), .group_pins_o(group_pins));

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Classic single cycle; the wait for ack is bounded
   task automatic wb(input logic we, input logic [9:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_req_i <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'h1, adr: a, dat: {24'h0, d}};
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (wb_rsp_o.ack !== 1'b1 && n < 20);
      if (wb_rsp_o.ack !== 1'b1)
      begin
         bad_count++;
         final_report();
      end
      rd = wb_rsp_o.dat;
      wb_req_i <= '0;
   endtask

   task automatic rd_chk(input string what, input logic [9:0] a, input logic [7:0] exp);
      wb(1'b0, a, 8'h00);
      check(what, {24'h0, exp}, rd);
   endtask

   // One-cycle vector acknowledge, as the core gives when it vectors
   task automatic ack(input logic [1:0] la, input logic [2:0] ga);
      @(posedge clk_i);
      line_ack_i  <= la;
      group_ack_i <= ga;
      @(posedge clk_i);
      line_ack_i  <= 2'h0;
      group_ack_i <= 3'h0;
   endtask

   // Main sequence
   initial
   begin
      srst_i      = 1'b1;
      cpu_gie_i   = 1'b0;
      line_ack_i  = 2'h0;
      group_ack_i = 3'h0;
      wb_req_i    = '0;
      bad_count   = 0;
      cmp_count   = 0;
      repeat (20) @(posedge clk_i);
      srst_i <= 1'b0;
      foreach (ra[i])
      begin
         rd_chk("reset value", ra[i], 8'h00);
         wb(1'b1, ra[i], 8'hff);
         rd_chk("all ones", ra[i], rv[i]);
         wb(1'b1, ra[i], 8'h00);
      end
      // Global enable reads back and shows on its copy to the core
      rd_chk("enable reset", A_GIE, 8'h00);
      check("enable copy off", 32'h0, 32'(cpu_gie_o));
      wb(1'b1, A_GIE, 8'h01);
      rd_chk("enable set", A_GIE, 8'h01);
      check("enable copy on", 32'h1, 32'(cpu_gie_o));
      // Every edge sense on each line; a low pulse is split into its two edges
      wb(1'b1, A_LEN, 8'h03);
      for (int l = 0; l < 2; l++)
         for (int m = 1; m < 4; m++)
         begin
            wb(1'b1, A_SEN, 8'(m << (2 * l)));
            wb(1'b1, A_LFL, 8'h03);
            u_epi_pin_model.set_line(l, 1'b0);
            eb = (m != 3) ? 8'(1 << l) : 8'h00;
            rd_chk("flag on fall", A_LFL, eb);
            check("irq on fall", {24'h0, eb}, 32'(line_irq_o));
            wb(1'b1, A_LFL, 8'h03);
            rd_chk("flag write one", A_LFL, 8'h00);
            u_epi_pin_model.set_line(l, 1'b1);
            eb = (m != 2) ? 8'(1 << l) : 8'h00;
            rd_chk("flag on rise", A_LFL, eb);
         end
      // Line 1 flag now set: enable and global gating, then the acknowledge
      wb(1'b1, A_LEN, 8'h01);
      check("irq line disabled", 32'h0, 32'(line_irq_o));
      wb(1'b1, A_LEN, 8'h03);
      wb(1'b1, A_GIE, 8'h00);
      check("irq global off", 32'h0, 32'(line_irq_o));
      wb(1'b1, A_GIE, 8'h01);
      check("irq global on", 32'h2, 32'(line_irq_o));
      ack(2'h2, 3'h0);
      rd_chk("flag after ack", A_LFL, 8'h00);
      // Low level: flag stays clear, request follows the pad
      wb(1'b1, A_SEN, 8'h00);
      u_epi_pin_model.set_line(0, 1'b0);
      rd_chk("level flag", A_LFL, 8'h00);
      check("level irq", 32'h1, 32'(line_irq_o));
      u_epi_pin_model.set_line(0, 1'b1);
      check("level released", 32'h0, 32'(line_irq_o));
      // Groups: only the masked pad raises; flags clear by ack or write-one
      wb(1'b1, A_GEN, 8'h07);
      for (int g = 0; g < 3; g++)
      begin
         eb = 8'(1 << g);
         wb(1'b1, 10'h1ac + 10'(4 * g), 8'h01);
         u_epi_pin_model.set_pins(~(24'h2 << (8 * g)));
         rd_chk("unmasked pad", A_GFL, 8'h00);
         u_epi_pin_model.set_pins(~(24'h3 << (8 * g)));
         rd_chk("group flag", A_GFL, eb);
         check("group irq", {24'h0, eb}, 32'(group_irq_o));
         // A set flag must not reach the core without both enables
         wb(1'b1, A_GEN, 8'h00);
         check("group irq enable off", 32'h0, 32'(group_irq_o));
         wb(1'b1, A_GEN, 8'h07);
         wb(1'b1, A_GIE, 8'h00);
         check("group irq global off", 32'h0, 32'(group_irq_o));
         wb(1'b1, A_GIE, 8'h01);
         ack(2'h0, 3'(eb));
         rd_chk("group ack", A_GFL, 8'h00);
         u_epi_pin_model.set_pins(24'hff_ffff);
         wb(1'b1, A_GFL, eb);
         rd_chk("group write one", A_GFL, 8'h00);
         wb(1'b1, 10'h1ac + 10'(4 * g), 8'h00);
      end
      final_report();
   end
endmodule
